// file: logic/uer_regs.sv
// uncorrectable error reporting registers of the upstream endpoint
`timescale 1ns/10ps
`default_nettype none
`include "uer_map.svh"

module uer_regs
	import uer_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        por,
	input  wire logic        perst_n,
	input  wire logic        global_reset_pin_n,
	input  wire logic        cfg_req,
	input  wire logic        cfg_wr,
	input  wire logic [11:0] cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output var  logic        cfg_ack,
	output var  logic [31:0] cfg_rdata,
	input  wire logic        unsupported_request_seen,
	input  wire logic        end_to_end_crc_seen,
	input  wire logic        malformed_packet_seen,
	input  wire logic        receive_credit_overflow_seen,
	input  wire logic        unexpected_completion_seen,
	input  wire logic        completer_abort_sent,
	input  wire logic        completion_timeout_seen,
	input  wire logic        flow_control_protocol_seen,
	input  wire logic        poisoned_packet_seen,
	input  wire logic        link_layer_protocol_seen,
	output var  logic        err_fatal_msg,
	output var  logic        err_nonfatal_msg,
	output var  logic        error_pending
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// map a dword address onto one of the registers
	function automatic uer_sel_t decode(input logic [11:0] addr);
		uer_sel_t sel;
		sel = UER_SEL_NONE;
		// compare at full width so the offsets keep their size
		case (addr >> 2)
			`UER_OFS_CAP_HDR  >> 2: sel = UER_SEL_CAP;
			`UER_OFS_FLAGS    >> 2: sel = UER_SEL_FLAGS;
			`UER_OFS_SUPPRESS >> 2: sel = UER_SEL_SUPPRESS;
			`UER_OFS_FATALITY >> 2: sel = UER_SEL_FATALITY;
			default:                sel = UER_SEL_NONE;
		endcase
		return sel;
	endfunction

	// expand byte enables into a bit mask
	function automatic uer_word_t lane_mask(input logic [3:0] be);
		uer_word_t m;
		m = '0;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{be[b]}};
		end
		return m;
	endfunction

	// merge written lanes into a writable register, implemented bits only
	function automatic uer_word_t lane_merge(input uer_word_t old, input uer_word_t wd,
	                                          input logic [3:0] be);
		uer_word_t m;
		m = lane_mask(be) & `UER_IMPL_BITS;
		return (old & ~m) | (wd & m);
	endfunction

	// ----------------------------------------------------------------
	// reset gathering
	// ----------------------------------------------------------------
	logic [1:0] pins_stable;  // {perst_n, global_reset_pin_n} after sync
	logic       blk_rst;      // any of the device resets

	// pins start out read as asserted so the bank stays in reset until they settle
	uer_pin_sync #(
		.W         (2),
		.RESET_VAL (2'b00)
	) u_pin_sync (
		.clock      (clock),
		.rst        (rst),
		.pin_in     ({perst_n, global_reset_pin_n}),
		.pin_stable (pins_stable)
	);

	// por comes from on-chip logic on this clock, so it needs no synchroniser
	assign blk_rst = rst | por | ~pins_stable[1] | ~pins_stable[0];

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	uer_word_t suppress_q;  // mask register, implemented bits only
	uer_word_t sev_q;       // writable severity bits
	uer_word_t sev_read;    // severity as software sees it
	uer_word_t event_vec;   // error strobes at their bit positions
	uer_word_t set_vec;     // errors that will be logged this cycle
	uer_word_t clr_vec;     // write-one-to-clear request
	uer_sel_t  acc_sel;     // register addressed by the current request
	logic      wr_hit;      // write strobe this cycle
	logic      rd_hit;      // read strobe this cycle

	uer_flag_if fl ();

	uer_flag_bank u_flag_bank (
		.clock   (clock),
		.blk_rst (blk_rst),
		.fl      (fl)
	);

	// ----------------------------------------------------------------
	// error event gathering
	// ----------------------------------------------------------------
	always_comb begin
		event_vec = '0;
		event_vec[`UER_BIT_UR]         = unsupported_request_seen;
		event_vec[`UER_BIT_ECRC]       = end_to_end_crc_seen;
		event_vec[`UER_BIT_MALFORMED]  = malformed_packet_seen;
		event_vec[`UER_BIT_OVERFLOW]   = receive_credit_overflow_seen;
		event_vec[`UER_BIT_UNEXP_CPL]  = unexpected_completion_seen;
		event_vec[`UER_BIT_COMPLETER_ABORT_FLAG]  = completer_abort_sent;
		event_vec[`UER_BIT_CPL_TOUT]   = completion_timeout_seen;
		event_vec[`UER_BIT_FC_PROTO]   = flow_control_protocol_seen;
		event_vec[`UER_BIT_POISONED]   = poisoned_packet_seen;
		event_vec[`UER_BIT_LINK_PROTO] = link_layer_protocol_seen;
	end

	// masked errors are dropped before they reach the flags or a message
	assign set_vec = event_vec & ~suppress_q & `UER_IMPL_BITS;

	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	assign acc_sel = decode(cfg_addr);
	assign wr_hit  = cfg_req & cfg_wr;
	assign rd_hit  = cfg_req & ~cfg_wr;

	// only ones in enabled lanes of a flags write clear anything
	assign clr_vec = (wr_hit && acc_sel == UER_SEL_FLAGS) ?
	                 (cfg_wdata & lane_mask(cfg_be)) : '0;

	assign fl.set_vec = set_vec;
	assign fl.clr_vec = clr_vec;

	// ----------------------------------------------------------------
	// mask register
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (blk_rst) begin
			suppress_q <= `UER_SUPPRESS_RESET;
		end else if (wr_hit && acc_sel == UER_SEL_SUPPRESS) begin
			suppress_q <= lane_merge(suppress_q, cfg_wdata, cfg_be);
		end
	end

	// ----------------------------------------------------------------
	// severity register
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (blk_rst) begin
			sev_q <= `UER_SEV_RESET & `UER_IMPL_BITS;
		end else if (wr_hit && acc_sel == UER_SEL_FATALITY) begin
			sev_q <= lane_merge(sev_q, cfg_wdata, cfg_be);
		end
	end

	// fixed ones are wired in at read time, never stored
	assign sev_read = sev_q | `UER_SEV_FIXED_ONES;

	// ----------------------------------------------------------------
	// configuration answer: one cycle after the request
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (blk_rst) begin
			cfg_ack <= 1'b0;
		end else begin
			cfg_ack <= cfg_req;
		end
	end

	// read data; writes and unmapped addresses return zero
	always_ff @(posedge clock) begin
		if (blk_rst) begin
			cfg_rdata <= '0;
		end else if (rd_hit) begin
			case (acc_sel)
				UER_SEL_CAP:      cfg_rdata <= {`UER_NEXT_VER, `UER_CAP_ID};
				UER_SEL_FLAGS:    cfg_rdata <= fl.flags;
				UER_SEL_SUPPRESS: cfg_rdata <= suppress_q;
				UER_SEL_FATALITY: cfg_rdata <= sev_read;
				default:          cfg_rdata <= '0;
			endcase
		end else begin
			cfg_rdata <= '0;
		end
	end

	// ----------------------------------------------------------------
	// error messages toward the link: at most one pulse of each kind per logging cycle
	// ----------------------------------------------------------------
	// several errors in one cycle yield at most one message of each kind,
	// which is what the message layer can take in one slot anyway
	always_ff @(posedge clock) begin
		if (blk_rst) begin
			err_fatal_msg    <= 1'b0;
			err_nonfatal_msg <= 1'b0;
		end else begin
			err_fatal_msg    <= |(set_vec & sev_q);
			err_nonfatal_msg <= |(set_vec & ~sev_q);
		end
	end

	// summary of any flag standing
	always_ff @(posedge clock) begin
		if (blk_rst) begin
			error_pending <= 1'b0;
		end else begin
			error_pending <= |((fl.flags & ~clr_vec) | set_vec);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	uer_sel_t rd_sel_q;  // register read by the previous request

	always_ff @(posedge clock) begin
		if (blk_rst) begin
			rd_sel_q <= UER_SEL_NONE;
		end else begin
			rd_sel_q <= rd_hit ? acc_sel : UER_SEL_NONE;
		end
	end

	chk_id_word: assert property (
		@(posedge clock) disable iff (blk_rst)
		rd_hit && acc_sel == UER_SEL_CAP |=> cfg_ack && cfg_rdata[31:20] == `UER_NEXT_PTR
			&& cfg_rdata[19:16] == `UER_CAP_VERSION && cfg_rdata[15:0] == `UER_CAP_ID)
		else $error("capability header word wrong");

	chk_reserved_zero: assert property (
		@(posedge clock) disable iff (blk_rst)
		(rd_sel_q == UER_SEL_FLAGS || rd_sel_q == UER_SEL_SUPPRESS)
			|-> (cfg_rdata & ~`UER_IMPL_BITS) == 32'h0000_0000)
		else $error("unassigned status or mask bit reads one");

	chk_sev_fixed: assert property (
		@(posedge clock) disable iff (blk_rst)
		rd_sel_q == UER_SEL_FATALITY
			|-> (cfg_rdata & ~(`UER_IMPL_BITS | `UER_SEV_FIXED_ONES)) == 32'h0000_0000
			&& cfg_rdata[22] && cfg_rdata[5])
		else $error("severity fixed bits wrong");

	chk_set_wins: assert property (
		@(posedge clock) disable iff (blk_rst)
		set_vec != 32'h0000_0000 |=> (fl.flags & $past(set_vec)) == $past(set_vec))
		else $error("logged error did not set its flag");

	chk_sticky_flags: assert property (
		@(posedge clock) disable iff (blk_rst)
		##1 ($past(fl.flags) & ~fl.flags & ~$past(clr_vec)) == 32'h0000_0000)
		else $error("flag fell without a clearing write");

	chk_w1c_clear: assert property (
		@(posedge clock) disable iff (blk_rst)
		clr_vec != 32'h0000_0000 && set_vec == 32'h0000_0000
			|=> (fl.flags & $past(clr_vec)) == 32'h0000_0000)
		else $error("written one did not clear its flag");

	chk_mask_blocks: assert property (
		@(posedge clock) disable iff (blk_rst)
		##1 (fl.flags & ~$past(fl.flags) & ~$past(event_vec & ~suppress_q)) == 32'h0000_0000)
		else $error("flag rose without an unmasked error");

	chk_msg_kind: assert property (
		@(posedge clock) disable iff (blk_rst)
		(set_vec & sev_q) != 32'h0000_0000 |=> err_fatal_msg ##1 !err_fatal_msg || $past(|(set_vec & sev_q)))
		else $error("fatal error gave no fatal message");

	chk_reset_values: assert property (
		@(posedge clock)
		$fell(blk_rst) |-> fl.flags == `UER_FLAGS_RESET && suppress_q == `UER_SUPPRESS_RESET
			&& sev_q == (`UER_SEV_RESET & `UER_IMPL_BITS))
		else $error("register not at default after reset");

	// ----------------------------------------------------------------
	// checks on messages, summary and full-lane register writes
	// ----------------------------------------------------------------
	// partial-lane writes are left to the bench, which drives its own lane patterns

	chk_nonfatal_kind: assert property (
		@(posedge clock) disable iff (blk_rst)
		(set_vec & ~sev_q) != 32'h0000_0000 |=> err_nonfatal_msg)
		else $error("non-fatal error gave no non-fatal message");

	chk_no_stray_msg: assert property (
		@(posedge clock) disable iff (blk_rst)
		set_vec == 32'h0000_0000 |=> !err_fatal_msg && !err_nonfatal_msg)
		else $error("message without a logged error");

	chk_pending_level: assert property (
		@(posedge clock) disable iff (blk_rst)
		error_pending == (fl.flags != 32'h0000_0000))
		else $error("pending summary disagrees with the flags");

	chk_suppress_write: assert property (
		@(posedge clock) disable iff (blk_rst)
		wr_hit && acc_sel == UER_SEL_SUPPRESS && cfg_be == 4'hF
			|=> suppress_q == ($past(cfg_wdata) & `UER_IMPL_BITS))
		else $error("mask write did not land on its bits");

	chk_fatality_write: assert property (
		@(posedge clock) disable iff (blk_rst)
		wr_hit && acc_sel == UER_SEL_FATALITY && cfg_be == 4'hF
			|=> sev_q == ($past(cfg_wdata) & `UER_IMPL_BITS))
		else $error("severity write did not land on its bits");
endmodule

`default_nettype wire

// file: logic/uer_map.svh
// register offsets, field positions, reset values and fixed bit patterns of the uncorrectable error bank
`ifndef UER_MAP_SVH
`define UER_MAP_SVH

// ----------------------------------------------------------------
// byte offsets in extended configuration space (dword aligned, except UER_OFS_NEXT_VER at the half-word 0x102)
// ----------------------------------------------------------------
`define UER_OFS_CAP_HDR    12'h100
`define UER_OFS_NEXT_VER   12'h102
`define UER_OFS_FLAGS      12'h104
`define UER_OFS_SUPPRESS   12'h108
`define UER_OFS_FATALITY   12'h10C

// ----------------------------------------------------------------
// capability header contents
// ----------------------------------------------------------------
`define UER_CAP_ID         16'h0001
`define UER_NEXT_VER       16'h1502
`define UER_NEXT_PTR       12'h150
`define UER_CAP_VERSION    4'h2

// ----------------------------------------------------------------
// error bit positions
// ----------------------------------------------------------------
`define UER_BIT_UR         20
`define UER_BIT_ECRC       19
`define UER_BIT_MALFORMED  18
`define UER_BIT_OVERFLOW   17
`define UER_BIT_UNEXP_CPL  16
`define UER_BIT_COMPLETER_ABORT_FLAG  15
`define UER_BIT_CPL_TOUT   14
`define UER_BIT_FC_PROTO   13
`define UER_BIT_POISONED   12
`define UER_BIT_LINK_PROTO 4

// ----------------------------------------------------------------
// implemented bits, fixed ones and reset values
// ----------------------------------------------------------------
`define UER_IMPL_BITS      32'h001F_F010
`define UER_SEV_FIXED_ONES 32'h0040_0020
`define UER_FLAGS_RESET    32'h0000_0000
`define UER_SUPPRESS_RESET 32'h0000_0000
`define UER_SEV_RESET      32'h0026_2030

`endif

// file: logic/uer_pkg.sv
// types shared by the uncorrectable error bank modules
package uer_pkg;

	// one configuration dword
	typedef logic [31:0] uer_word_t;

	// register selected by a configuration access
	typedef enum {
		UER_SEL_CAP,
		UER_SEL_FLAGS,
		UER_SEL_SUPPRESS,
		UER_SEL_FATALITY,
		UER_SEL_NONE
	} uer_sel_t;

endpackage

// file: logic/uer_flag_if.sv
// carrier between the register front end and the sticky flag bank
`timescale 1ns/10ps
`default_nettype none

interface uer_flag_if;
	logic [31:0] set_vec;   // one-cycle set requests, already masked
	logic [31:0] clr_vec;   // one-cycle write-one-to-clear requests
	logic [31:0] flags;     // current sticky flags

	modport bank (input set_vec, input clr_vec, output flags);
	modport ctrl (output set_vec, output clr_vec, input flags);
endinterface

`default_nettype wire

// file: logic/uer_pin_sync.sv
// three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/10ps
`default_nettype none

module uer_pin_sync #(
	parameter int          W         = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic [W-1:0] pin_in,
	output var  logic [W-1:0] pin_stable
);
	logic [W-1:0] s1_q;  // metastability catcher, read only by s2_q
	logic [W-1:0] s2_q;  // second stage
	logic [W-1:0] s3_q;  // third stage

	// ----------------------------------------------------------------
	// synchroniser chain
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		s1_q <= pin_in;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end

	// ----------------------------------------------------------------
	// accept a change only once stages two and three agree
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			pin_stable <= RESET_VAL;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					pin_stable[i] <= s3_q[i];
				end
			end
		end
	end
endmodule

`default_nettype wire

// file: logic/uer_flag_bank.sv
// sticky error flags: set by hardware, cleared by writing ones, set wins
`timescale 1ns/10ps
`default_nettype none
`include "uer_map.svh"

module uer_flag_bank (
	input  wire logic clock,
	input  wire logic blk_rst,
	uer_flag_if.bank  fl
);
	logic [31:0] flags_q;  // stored flags

	// ----------------------------------------------------------------
	// flag update: a set in the clearing cycle survives
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (blk_rst) begin
			flags_q <= `UER_FLAGS_RESET;
		end else begin
			// unimplemented positions never hold a one
			flags_q <= ((flags_q & ~fl.clr_vec) | fl.set_vec) & `UER_IMPL_BITS;
		end
	end

	assign fl.flags = flags_q;
endmodule

`default_nettype wire

// file: verification/uer_cfg_host.sv
// configuration host model that issues single accesses to the error bank
`timescale 1ns/10ps
`default_nettype none

module uer_cfg_host (
	input  wire logic        clock,
	output var  logic        cfg_req,
	output var  logic        cfg_wr,
	output var  logic [11:0] cfg_addr,
	output var  logic [3:0]  cfg_be,
	output var  logic [31:0] cfg_wdata,
	input  wire logic        cfg_ack,
	input  wire logic [31:0] cfg_rdata
);
	// ----------------------------------------------------------------
	// idle values at time zero
	// ----------------------------------------------------------------
	initial begin
		cfg_req   = 1'b0;
		cfg_wr    = 1'b0;
		cfg_addr  = 12'h000;
		cfg_be    = 4'h0;
		cfg_wdata = 32'h0000_0000;
	end

	// ----------------------------------------------------------------
	// one access: a single-cycle strobe, then a bounded wait for the answer
	// ----------------------------------------------------------------
	task automatic access(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
		input logic [3:0] be, output logic [31:0] rdata, output logic ok);
		int n;
		@(posedge clock);
		cfg_req   <= 1'b1;
		cfg_wr    <= wr;
		cfg_addr  <= addr;
		cfg_be    <= be;
		cfg_wdata <= wdata;
		@(posedge clock);
		// released write, address and data lines carry the inverse and enables go to zero, so a stale value is never read as live
		cfg_req   <= 1'b0;
		cfg_wr    <= ~wr;
		cfg_addr  <= ~addr;
		cfg_be    <= 4'h0;
		cfg_wdata <= ~wdata;
		#1;
		n = 0;
		while (cfg_ack !== 1'b1 && n < 4) begin
			@(posedge clock);
			#1;
			n++;
		end
		ok    = (cfg_ack === 1'b1);
		rdata = cfg_rdata;
	endtask
endmodule

`default_nettype wire

// file: verification/tb_uer_regs.sv
// self-checking testbench for the uncorrectable error register bank
`timescale 1ns/10ps
`default_nettype none

module tb_uer_regs;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clock;              // 10 MHz core clock
	logic        rst;                // synchronous reset
	logic        por;                // power-on reset
	logic        perst_n;            // link reset pin
	logic        global_reset_pin_n; // global reset pin
	logic        cfg_req;            // access strobe from the host model
	logic        cfg_wr;             // write select
	logic [11:0] cfg_addr;           // byte address
	logic [3:0]  cfg_be;             // byte enables
	logic [31:0] cfg_wdata;          // write data
	logic        cfg_ack;            // answer strobe
	logic [31:0] cfg_rdata;          // read data
	logic [9:0]  err_vec;            // error strobes, bit 9 is unsupported request
	logic        err_fatal_msg;      // fatal message pulse
	logic        err_nonfatal_msg;   // non-fatal message pulse
	logic        error_pending;      // any flag set
	logic [31:0] bit_v;              // flag bit under test
	int          failures;           // mismatches
	int          compares;           // comparisons made

	// ----------------------------------------------------------------
	// clock and instances
	// ----------------------------------------------------------------
	always #50 clock = ~clock;

	uer_cfg_host uer_cfg_host_inst (.clock(clock), .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
		.cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));

	uer_regs uer_regs_inst (.clock(clock), .rst(rst), .por(por), .perst_n(perst_n),
		.global_reset_pin_n(global_reset_pin_n), .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
		.cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
		.unsupported_request_seen(err_vec[9]), .end_to_end_crc_seen(err_vec[8]),
		.malformed_packet_seen(err_vec[7]), .receive_credit_overflow_seen(err_vec[6]),
		.unexpected_completion_seen(err_vec[5]), .completer_abort_sent(err_vec[4]),
		.completion_timeout_seen(err_vec[3]), .flow_control_protocol_seen(err_vec[2]),
		.poisoned_packet_seen(err_vec[1]), .link_layer_protocol_seen(err_vec[0]),
		.err_fatal_msg(err_fatal_msg), .err_nonfatal_msg(err_nonfatal_msg), .error_pending(error_pending));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check_value(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// message and pending outputs packed as {fatal, nonfatal, pending}
	function automatic logic [31:0] msgs();
		return {29'h0000_0000, err_fatal_msg, err_nonfatal_msg, error_pending};
	endfunction

	task automatic reg_access(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
		input logic [3:0] be, output logic [31:0] rdata);
		logic ok;
		uer_cfg_host_inst.access(wr, addr, wdata, be, rdata, ok);
		// a missing answer ends the run instead of hanging it
		if (!ok) begin
			failures++;
			$display("[ERR] %0t no answer to access", $time);
			complete_run();
		end
	endtask

	task automatic reg_wr(input logic [11:0] addr, input logic [31:0] data);
		logic [31:0] unused;
		reg_access(1'b1, addr, data, 4'hF, unused);
	endtask

	// write with chosen byte lanes only
	task automatic reg_wr_lanes(input logic [11:0] addr, input logic [31:0] data, input logic [3:0] be);
		logic [31:0] unused;
		reg_access(1'b1, addr, data, be, unused);
	endtask

	task automatic reg_check(input logic [11:0] addr, input logic [31:0] exp);
		logic [31:0] data;
		reg_access(1'b0, addr, 32'h0000_0000, 4'hF, data);
		check_value(data, exp);
	endtask

	// one-cycle strobe pattern; returns once the answering edge has landed
	task automatic pulse(input logic [9:0] v);
		@(posedge clock);
		err_vec <= v;
		@(posedge clock);
		err_vec <= 10'h000;
		#1;
	endtask

	// each reset source in turn: 0 rst, 1 power-on, 2 link pin, 3 global pin
	task automatic hit_reset(input int k);
		@(posedge clock);
		case (k)
			0: rst <= 1'b1;
			1: por <= 1'b1;
			2: perst_n <= 1'b0;
			default: global_reset_pin_n <= 1'b0;
		endcase
		repeat (6) @(posedge clock);
		rst                <= 1'b0;
		por                <= 1'b0;
		perst_n            <= 1'b1;
		global_reset_pin_n <= 1'b1;
		// pins pass a three-stage synchroniser before the block leaves reset
		repeat (6) @(posedge clock);
	endtask

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		$display("[ERR] %0t run did not finish", $time);
		complete_run();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		clock              = 1'b0;
		rst                = 1'b1;
		por                = 1'b0;
		perst_n            = 1'b1;
		global_reset_pin_n = 1'b1;
		err_vec            = 10'h000;
		failures           = 0;
		compares           = 0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		repeat (5) @(posedge clock);
		// identity word, defaults and read-only places
		reg_check(12'h100, 32'h1502_0001);
		reg_check(12'h104, 32'h0000_0000);
		reg_check(12'h108, 32'h0000_0000);
		reg_check(12'h10C, 32'h0046_2030);
		reg_wr(12'h100, 32'hFFFF_FFFF);
		reg_check(12'h100, 32'h1502_0001);
		reg_check(12'h200, 32'h0000_0000);
		// only the assigned bits take a write
		reg_wr(12'h108, 32'hFFFF_FFFF);
		reg_check(12'h108, 32'h001F_F010);
		reg_wr(12'h10C, 32'hFFFF_FFFF);
		reg_check(12'h10C, 32'h005F_F030);
		// every error masked: nothing logged, nothing signalled
		pulse(10'h3FF);
		check_value(msgs(), 32'h0000_0000);
		reg_check(12'h104, 32'h0000_0000);
		// lane-wise mask write: lane 2 keeps its ones, so bits 15:12 and 4 log
		reg_wr_lanes(12'h108, 32'h0000_0000, 4'hB);
		reg_check(12'h108, 32'h001F_0000);
		pulse(10'h3FF);
		check_value(msgs(), 32'h0000_0005);
		reg_check(12'h104, 32'h0000_F010);
		// a clear that meets a new error of the same kind loses to it
		fork
			pulse(10'h002);
			reg_wr(12'h104, 32'h0000_1000);
		join
		reg_check(12'h104, 32'h0000_F010);
		reg_wr(12'h104, 32'hFFFF_FFFF);
		reg_check(12'h104, 32'h0000_0000);
		reg_wr(12'h108, 32'h0000_0000);
		// each error alone, non-fatal then fatal, with write-one-to-clear
		for (int i = 0; i < 10; i++) begin
			// strobe 9-i sits at flag bit 20-i, the last one at bit 4
			bit_v = (i < 9) ? (32'h0010_0000 >> i) : 32'h0000_0010;
			reg_wr(12'h10C, 32'h0000_0000);
			pulse(10'h200 >> i);
			check_value(msgs(), 32'h0000_0003);
			repeat (3) @(posedge clock);
			reg_check(12'h104, bit_v);
			reg_wr(12'h104, ~bit_v);
			reg_check(12'h104, bit_v);
			reg_wr(12'h10C, bit_v);
			pulse(10'h200 >> i);
			check_value(msgs(), 32'h0000_0005);
			reg_wr(12'h104, bit_v);
			check_value(msgs(), 32'h0000_0000);
			reg_check(12'h104, 32'h0000_0000);
		end
		// every reset source restores the defaults
		for (int k = 0; k < 4; k++) begin
			pulse(10'h3FF);
			reg_check(12'h104, 32'h001F_F010);
			reg_wr(12'h108, 32'hFFFF_FFFF);
			reg_wr(12'h10C, 32'h0000_0000);
			hit_reset(k);
			reg_check(12'h104, 32'h0000_0000);
			reg_check(12'h108, 32'h0000_0000);
			reg_check(12'h10C, 32'h0046_2030);
		end
		complete_run();
	end
endmodule

`default_nettype wire
